// ===== hw/mrlg_pkg.sv
/*
   shared constants and types for the mirror-rest / light-gate / serial-master link.
   assumes a single 20 MHz clock on both ends.
*/
package mrlg_pkg;
   // clock and timing
   localparam int unsigned CLK_HZ          = 20_000_000;
   localparam int unsigned REST_LEAD_US    = 500;
   localparam int unsigned LIGHT_DELAY_MS  = 100;
   localparam int unsigned I2C_HOLD_MS     = 100;
   localparam int unsigned REST_CYC_DFLT   = REST_LEAD_US * (CLK_HZ / 1_000_000);
   localparam int unsigned LIGHT_CYC_DFLT  = LIGHT_DELAY_MS * (CLK_HZ / 1_000);
   localparam int unsigned I2C_CYC_DFLT    = I2C_HOLD_MS * (CLK_HZ / 1_000);
   localparam int unsigned CNT_W           = 21;

   // serial bus
   localparam int unsigned BYTE_W          = 8;
   localparam logic [7:0]  FLASH_READ_CMD  = 8'h03;
   localparam logic [7:0]  ADDR_FILL       = 8'h00;
   localparam logic [2:0]  CFG_FIRST_DATA  = 3'h4;
   localparam logic [2:0]  CFG_LAST_BYTE   = 3'h7;
   localparam int unsigned CFG_W           = 32;

   // host register map
   localparam logic [31:0] CTRL_OFS        = 32'h0000_0000;
   localparam logic [31:0] STATUS_OFS      = 32'h0000_0004;
   localparam int unsigned CTRL_POWER_BIT  = 0;
   localparam int unsigned CTRL_LIGHT_BIT  = 1;
   localparam int unsigned CTRL_W          = 2;
   localparam logic [1:0]  CTRL_RESET      = 2'h0;
   localparam int unsigned ST_SUPPLY_BIT   = 0;
   localparam int unsigned ST_RESET_BIT    = 1;
   localparam int unsigned ST_REST_BIT     = 2;
   localparam int unsigned ST_I2C_BIT      = 3;
   localparam int unsigned ST_LIGHT_BIT    = 4;
   localparam int unsigned ST_MIRROR_BIT   = 5;
   localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
   localparam logic        HRESP_OKAY      = 1'b0;

   typedef enum logic [1:0] {DEV_OFF, DEV_CFG, DEV_READY, DEV_XFER} mrlg_dev_state_t;
   typedef enum logic [1:0] {HST_OFF, HST_START, HST_RUN, HST_PARK} mrlg_host_state_t;
endpackage

// ===== hw/mrlg_link_if.sv
/*
   link between the host sequencer and the display-controller end.
   assumes the bench resolves tri-state pins from the _oe signals and drives serial_bus_miso.
*/
`timescale 1ns/10ps
`default_nettype none
interface mrlg_link_if;
   logic       power_on_reset_n;
   logic       mirror_rest_n;
   logic       light_source_enable;
   logic       mirror_power_enable;
   logic       mirror_power_enable_oe;
   logic       light_driver_on;
   logic       light_driver_on_oe;
   logic [1:0] light_select;
   logic       light_select_oe;
   logic       serial_bus_clock;
   logic       serial_bus_clock_oe;
   logic       serial_bus_mosi;
   logic       serial_bus_mosi_oe;
   logic       flash_select_n;
   logic       flash_select_n_oe;
   logic       pmic_select_n;
   logic       serial_bus_miso;

   modport device (
      input  power_on_reset_n, mirror_rest_n, light_source_enable, serial_bus_miso,
      output mirror_power_enable, mirror_power_enable_oe, light_driver_on,
      output light_driver_on_oe, light_select, light_select_oe, serial_bus_clock,
      output serial_bus_clock_oe, serial_bus_mosi, serial_bus_mosi_oe,
      output flash_select_n, flash_select_n_oe, pmic_select_n
   );
   modport host (
      output power_on_reset_n, mirror_rest_n, light_source_enable,
      input  mirror_power_enable, mirror_power_enable_oe, light_driver_on, light_driver_on_oe
   );
endinterface
`default_nettype wire

// ===== hw/mrlg_device.sv
/*
   display-controller end: power-on self-configuration over the serial bus,
   light-driver gating, mirror power enable and a byte-wide serial master port.
   assumes power_on_reset_n, mirror_rest_n, light_source_enable and serial_bus_miso
   are synchronous to hclk.
*/
`timescale 1ns/10ps
`default_nettype none
// Contract
// - flash chip select is active low
// - companion chip select is active low
// - send command, address, write data on mosi
// - sample miso on self-made serial clock
// - host holds mirror-rest high for operation
// - host raises mirror-rest within 500 us
// - host parks mirror 500 us before power-off
// - enable low forces light outputs off
// - light outputs wait 100 ms after enable
// - host waits 100 ms before I2C
// - reset rising edge starts self-configuration
// - listed outputs tri-state during reset
module mrlg_device #(
   parameter int unsigned LIGHT_CYC = mrlg_pkg::LIGHT_CYC_DFLT
) (
   input  wire logic                        hclk,
   input  wire logic                        hresetn,
   mrlg_link_if.device                      link,
   input  wire logic                        cmd_valid,
   output logic                             cmd_ready,
   input  wire logic                        cmd_pmic,
   input  wire logic [mrlg_pkg::BYTE_W-1:0] cmd_data,
   input  wire logic                        cmd_hold,
   output logic                             rsp_valid,
   output logic [mrlg_pkg::BYTE_W-1:0]      rsp_data,
   output logic                             cfg_done,
   output logic [mrlg_pkg::CFG_W-1:0]       cfg_word,
   input  wire logic                        light_on_req,
   input  wire logic [1:0]                  light_select_req
);
   import mrlg_pkg::*;

   typedef struct packed {
      mrlg_dev_state_t   st;
      logic              por;
      logic              lse;
      logic [CNT_W-1:0]  light_cnt;
      logic              light_ok;
      logic              drv;
      logic [1:0]        lsel;
      logic              mpe;
      logic              run;
      logic              sclk;
      logic              cs_act;
      logic              tgt;
      logic              hold;
      logic [BYTE_W-1:0] sh;
      logic [BYTE_W-1:0] rx;
      logic [2:0]        nbit;
      logic [2:0]        idx;
      logic              rsp_v;
      logic [BYTE_W-1:0] rsp_d;
      logic              done;
      logic [CFG_W-1:0]  cfg;
   } mrlg_dev_t;

   mrlg_dev_t q;
   mrlg_dev_t d;
   logic      accept;

   // a held select for one target must drop before the other target is served
   assign accept = (q.st == DEV_READY) && link.power_on_reset_n
                   && (!q.cs_act || (q.tgt == cmd_pmic));
   assign cmd_ready = accept;

   always_comb begin
      d       = q;
      d.rsp_v = 1'b0;
      d.por   = link.power_on_reset_n;
      d.lse   = link.light_source_enable;

      // light gating
      if (!link.light_source_enable) begin
         d.light_cnt = '0;
         d.light_ok  = 1'b0;
      end else if (!q.lse) begin
         d.light_cnt = '0;
         d.light_ok  = 1'b0;
      end else if (!q.light_ok) begin
         if (q.light_cnt == CNT_W'(LIGHT_CYC - 1)) begin
            d.light_ok = 1'b1;
         end else begin
            d.light_cnt = q.light_cnt + CNT_W'(1);
         end
      end
      d.drv  = d.light_ok && light_on_req;
      d.lsel = d.light_ok ? light_select_req : 2'h0;

      // byte engine: mosi changes on the falling edge, miso is taken on the rising edge
      if (q.run) begin
         if (!q.sclk) begin
            d.sclk = 1'b1;
            d.rx   = {q.rx[BYTE_W-2:0], link.serial_bus_miso};
         end else begin
            d.sclk = 1'b0;
            d.sh   = {q.sh[BYTE_W-2:0], 1'b0};
            d.nbit = q.nbit + 3'h1;
            if (q.nbit == 3'h7) begin
               d.run = 1'b0;
            end
         end
      end

      unique case (q.st)
         DEV_OFF: begin
            if (link.power_on_reset_n && !q.por) begin
               d.st     = DEV_CFG;
               d.idx    = 3'h0;
               d.sh     = FLASH_READ_CMD;
               d.run    = 1'b1;
               d.cs_act = 1'b1;
               d.tgt    = 1'b0;
            end
         end
         DEV_CFG: begin
            if (!q.run) begin
               if (q.idx >= CFG_FIRST_DATA) begin
                  d.cfg = {q.cfg[CFG_W-BYTE_W-1:0], q.rx};
               end
               if (q.idx == CFG_LAST_BYTE) begin
                  d.cs_act = 1'b0;
                  d.done   = 1'b1;
                  d.st     = DEV_READY;
               end else begin
                  d.idx = q.idx + 3'h1;
                  d.sh  = ADDR_FILL;
                  d.run = 1'b1;
               end
            end
         end
         DEV_READY: begin
            if (cmd_valid && accept) begin
               d.st     = DEV_XFER;
               d.tgt    = cmd_pmic;
               d.cs_act = 1'b1;
               d.sh     = cmd_data;
               d.hold   = cmd_hold;
               d.run    = 1'b1;
            end else if (cmd_valid) begin
               d.cs_act = 1'b0;
            end
         end
         DEV_XFER: begin
            if (!q.run) begin
               d.rsp_v = 1'b1;
               d.rsp_d = q.rx;
               d.st    = DEV_READY;
               if (!q.hold) begin
                  d.cs_act = 1'b0;
               end
            end
         end
      endcase

      // mirror power follows configuration and the rest request
      d.mpe = d.done && link.mirror_rest_n;

      if (!link.power_on_reset_n) begin
         d.st     = DEV_OFF;
         d.run    = 1'b0;
         d.sclk   = 1'b0;
         d.nbit   = 3'h0;
         d.cs_act = 1'b0;
         d.done   = 1'b0;
         d.mpe    = 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '{st: DEV_OFF, default: '0};
      end else begin
         q <= d;
      end
   end

   assign link.mirror_power_enable    = q.mpe;
   assign link.light_driver_on        = q.drv;
   assign link.light_select           = q.lsel;
   assign link.serial_bus_clock       = q.sclk;
   assign link.serial_bus_mosi        = q.sh[BYTE_W-1];
   assign link.flash_select_n         = !(q.cs_act && !q.tgt);
   assign link.pmic_select_n          = !(q.cs_act && q.tgt);
   assign link.mirror_power_enable_oe = link.power_on_reset_n;
   assign link.light_driver_on_oe     = link.power_on_reset_n;
   assign link.light_select_oe        = link.power_on_reset_n;
   assign link.serial_bus_clock_oe    = link.power_on_reset_n;
   assign link.serial_bus_mosi_oe     = link.power_on_reset_n;
   assign link.flash_select_n_oe      = link.power_on_reset_n;

   assign rsp_valid = q.rsp_v;
   assign rsp_data  = q.rsp_d;
   assign cfg_done  = q.done;
   assign cfg_word  = q.cfg;
endmodule
`default_nettype wire

// ===== hw/mrlg_host.sv
/*
   host end: power-up and shutdown sequencer for the display controller,
   driven by software over an AHB-Lite slave with a control and a status word.
   assumes one AHB-Lite master and zero-wait answers.
*/
`timescale 1ns/10ps
`default_nettype none
module mrlg_host #(
   parameter int unsigned REST_CYC = mrlg_pkg::REST_CYC_DFLT,
   parameter int unsigned I2C_CYC  = mrlg_pkg::I2C_CYC_DFLT
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   mrlg_link_if.host        link,
   output logic             supply_enable,
   output logic             i2c_allowed
);
   import mrlg_pkg::*;

   typedef struct packed {
      mrlg_host_state_t st;
      logic [CTRL_W-1:0] ctrl;
      logic              wr_pend;
      logic [31:0]       waddr;
      logic [31:0]       rdata;
      logic [CNT_W-1:0]  cnt;
      logic              supply;
      logic              por;
      logic              rest;
      logic              lse;
      logic              i2c_ok;
   } mrlg_host_reg_t;

   mrlg_host_reg_t q;
   mrlg_host_reg_t d;
   logic           addr_ok;
   logic [31:0]    status;

   assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ) && (hsize == 3'h2);

   always_comb begin
      status                = 32'h0000_0000;
      status[ST_SUPPLY_BIT] = q.supply;
      status[ST_RESET_BIT]  = q.por;
      status[ST_REST_BIT]   = q.rest;
      status[ST_I2C_BIT]    = q.i2c_ok;
      status[ST_LIGHT_BIT]  = q.lse;
      status[ST_MIRROR_BIT] = link.mirror_power_enable && link.mirror_power_enable_oe;
   end

   always_comb begin
      d         = q;
      d.wr_pend = addr_ok && hwrite;
      d.waddr   = haddr;
      d.rdata   = 32'h0000_0000;
      if (addr_ok && !hwrite) begin
         if (haddr == CTRL_OFS) begin
            d.rdata = {{(32 - CTRL_W){1'b0}}, q.ctrl};
         end else if (haddr == STATUS_OFS) begin
            d.rdata = status;
         end
      end
      if (q.wr_pend && (q.waddr == CTRL_OFS)) begin
         d.ctrl = hwdata[CTRL_W-1:0];
      end

      unique case (q.st)
         HST_OFF: begin
            if (q.ctrl[CTRL_POWER_BIT]) begin
               d.supply = 1'b1;
               d.st     = HST_START;
            end
         end
         HST_START: begin
            d.rest = 1'b1;
            d.por  = 1'b1;
            d.cnt  = '0;
            d.st   = HST_RUN;
         end
         HST_RUN: begin
            d.lse = q.ctrl[CTRL_LIGHT_BIT];
            if (!q.i2c_ok) begin
               if (q.cnt == CNT_W'(I2C_CYC - 1)) begin
                  d.i2c_ok = 1'b1;
               end else begin
                  d.cnt = q.cnt + CNT_W'(1);
               end
            end
            if (!q.ctrl[CTRL_POWER_BIT]) begin
               d.rest   = 1'b0;
               d.lse    = 1'b0;
               d.i2c_ok = 1'b0;
               d.cnt    = '0;
               d.st     = HST_PARK;
            end
         end
         HST_PARK: begin
            if (q.cnt == CNT_W'(REST_CYC - 1)) begin
               d.por    = 1'b0;
               d.supply = 1'b0;
               d.st     = HST_OFF;
            end else begin
               d.cnt = q.cnt + CNT_W'(1);
            end
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q <= '{st: HST_OFF, ctrl: CTRL_RESET, default: '0};
      end else begin
         q <= d;
      end
   end

   assign hreadyout                = 1'b1;
   assign hresp                    = HRESP_OKAY;
   assign hrdata                   = q.rdata;
   assign link.power_on_reset_n    = q.por;
   assign link.mirror_rest_n       = q.rest;
   assign link.light_source_enable = q.lse;
   assign supply_enable            = q.supply;
   assign i2c_allowed              = q.i2c_ok;
endmodule
`default_nettype wire

// ===== verification/mrlg_link_monitor.sv
/*
   assertions on the link that joins the host and device ends.
   assumes one clock hclk and the bench reset hresetn shared by both ends.
*/
`timescale 1ns/10ps
`default_nettype none
module mrlg_link_monitor #(
   parameter int unsigned LIGHT_CYC = 20
) (
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic       power_on_reset_n,
   input wire logic       mirror_rest_n,
   input wire logic       light_source_enable,
   input wire logic       mirror_power_enable,
   input wire logic       mirror_power_enable_oe,
   input wire logic       light_driver_on,
   input wire logic       light_driver_on_oe,
   input wire logic [1:0] light_select,
   input wire logic       light_select_oe,
   input wire logic       serial_bus_clock,
   input wire logic       serial_bus_clock_oe,
   input wire logic       serial_bus_mosi,
   input wire logic       serial_bus_mosi_oe,
   input wire logic       flash_select_n,
   input wire logic       flash_select_n_oe,
   input wire logic       pmic_select_n
);
   logic [7:0] lse_cnt_q;
   logic [7:0] lse_cnt_d;

   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // cycles since the light enable went high
   always_comb begin
      lse_cnt_d = lse_cnt_q;
      if (!light_source_enable) lse_cnt_d = 8'h00;
      else if (lse_cnt_q != 8'hFF) lse_cnt_d = lse_cnt_q + 8'h01;
   end
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) lse_cnt_q <= 8'h00;
      else lse_cnt_q <= lse_cnt_d;
   end

   one_select_a : assert property (!(!flash_select_n && !pmic_select_n))
      else $error("both chip selects low");
   light_forced_a : assert property (!light_source_enable |=>
      !light_driver_on && light_select == 2'h0) else $error("light not forced off");
   light_hold_a : assert property ($rose(light_source_enable) |=> !light_driver_on [*8])
      else $error("light driver on too early");
   light_count_a : assert property (light_driver_on |-> lse_cnt_q >= LIGHT_CYC)
      else $error("light driver on before delay");
   tristate_reset_a : assert property (!power_on_reset_n |-> !(mirror_power_enable_oe ||
      light_driver_on_oe || light_select_oe || serial_bus_clock_oe || serial_bus_mosi_oe ||
      flash_select_n_oe)) else $error("output driven during reset");
   config_start_a : assert property ($rose(power_on_reset_n) |-> ##[1:2] !flash_select_n)
      else $error("self configuration did not start");
   clock_framed_a : assert property ($rose(serial_bus_clock) |->
      !flash_select_n || !pmic_select_n) else $error("serial clock outside a frame");
   mosi_stable_a : assert property (serial_bus_clock |-> $stable(serial_bus_mosi))
      else $error("data changed while serial clock high");
   mirror_rest_a : assert property (mirror_power_enable |-> $past(mirror_rest_n))
      else $error("mirror powered while parked");
   rest_with_reset_a : assert property ($rose(power_on_reset_n) |-> mirror_rest_n)
      else $error("mirror rest low at reset release");
   rest_lead_a : assert property ($fell(power_on_reset_n) |-> $past(mirror_rest_n, 8) == 1'b0)
      else $error("reset dropped too soon after park");
endmodule
`default_nettype wire

// ===== verification/tb.sv
/*
   bench joining host and device ends through the link interface.
   assumes short timing parameters and a miso line looped back inverted.
*/
`timescale 1ns/10ps
`default_nettype none
module tb;
   import mrlg_pkg::*;
   logic        hclk = 1'b0;
   logic        hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd, cfg_word;
   logic [1:0]  htrans, light_select_req;
   logic [2:0]  hsize;
   logic        supply_enable, i2c_allowed, cmd_valid, cmd_ready, cmd_pmic, cmd_hold;
   logic        rsp_valid, cfg_done, light_on_req;
   logic        pmic_seen = 1'b0;
   logic [7:0]  cmd_data, rsp_data;
   logic [7:0]  cap = 8'h00;
   int          nbits = 0;
   int          mismatches, num_checks;

   mrlg_link_if link ();
   mrlg_host #(.REST_CYC(10), .I2C_CYC(20)) i_mrlg_host (.hclk, .hresetn, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .link,
      .supply_enable, .i2c_allowed);
   mrlg_device #(.LIGHT_CYC(20)) i_mrlg_device (.hclk, .hresetn, .link, .cmd_valid,
      .cmd_ready, .cmd_pmic, .cmd_data, .cmd_hold, .rsp_valid, .rsp_data, .cfg_done,
      .cfg_word, .light_on_req, .light_select_req);
   mrlg_link_monitor #(.LIGHT_CYC(20)) i_mrlg_link_monitor (.hclk, .hresetn,
      .power_on_reset_n(link.power_on_reset_n), .mirror_rest_n(link.mirror_rest_n),
      .light_source_enable(link.light_source_enable),
      .mirror_power_enable(link.mirror_power_enable),
      .mirror_power_enable_oe(link.mirror_power_enable_oe),
      .light_driver_on(link.light_driver_on), .light_driver_on_oe(link.light_driver_on_oe),
      .light_select(link.light_select), .light_select_oe(link.light_select_oe),
      .serial_bus_clock(link.serial_bus_clock), .serial_bus_clock_oe(link.serial_bus_clock_oe),
      .serial_bus_mosi(link.serial_bus_mosi), .serial_bus_mosi_oe(link.serial_bus_mosi_oe),
      .flash_select_n(link.flash_select_n), .flash_select_n_oe(link.flash_select_n_oe),
      .pmic_select_n(link.pmic_select_n));

   assign hready = hreadyout;
   assign link.serial_bus_miso = ~link.serial_bus_mosi;

   always #25 hclk = ~hclk;

   // first flash byte on the wire, msb first
   always @(posedge link.serial_bus_clock) begin
      if (link.flash_select_n === 1'b0 && nbits < 8) begin
         cap = {cap[6:0], link.serial_bus_mosi};
         nbits++;
      end
   end
   always @(posedge hclk) begin
      if (link.pmic_select_n === 1'b0) pmic_seen <= 1'b1;
   end

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wait_for(ref logic s, input logic v, input int lim);
      int n;
      n = 0;
      do begin
         @(negedge hclk);
         n++;
      end while (s !== v && n < lim);
      if (s !== v) begin
         mismatches++;
         $display("[FAIL] wait expected %b seen %b", v, s);
         wrap_up();
      end
   endtask

   task automatic wait_ready();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 20);
      if (hready !== 1'b1) begin
         mismatches++;
         $display("[FAIL] hready expected 1 seen %b", hready);
         wrap_up();
      end
   endtask

   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      hsize <= 3'h2;
      wait_ready();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask

   task automatic xfer(input logic pmic, input logic hold, input logic [7:0] b);
      @(posedge hclk);
      cmd_valid <= 1'b1;
      cmd_pmic <= pmic;
      cmd_hold <= hold;
      cmd_data <= b;
      wait_for(cmd_ready, 1'b1, 40);
      @(posedge hclk);
      cmd_valid <= 1'b0;
      wait_for(rsp_valid, 1'b1, 40);
      check("response byte", rsp_data, 8'(~b));
   endtask

   task automatic t_power();
      ahb(1'b1, CTRL_OFS, 32'h1);
      wait_for(link.power_on_reset_n, 1'b1, 20);
      check("rest at release", link.mirror_rest_n, 1'b1);
      check("supply on", supply_enable, 1'b1);
      check("bus response", hresp, HRESP_OKAY);
      check("i2c held", i2c_allowed, 1'b0);
      repeat (10) @(negedge hclk);
      check("i2c still held", i2c_allowed, 1'b0);
      wait_for(cfg_done, 1'b1, 600);
      check("first flash byte", cap, FLASH_READ_CMD);
      check("config word", cfg_word, ~{4{ADDR_FILL}});
      check("flash selected", nbits, 8);
      check("i2c allowed", i2c_allowed, 1'b1);
      ahb(1'b0, STATUS_OFS, 32'h0);
      check("status", rd, 32'h2F);
      ahb(1'b0, 32'h8, 32'h0);
      check("unmapped read", rd, 32'h0);
      $display("power test done");
   endtask

   task automatic t_cmd();
      xfer(1'b1, 1'b1, 8'hA5);
      check("select held", link.pmic_select_n, 1'b0);
      xfer(1'b0, 1'b0, 8'h3C);
      check("companion released", link.pmic_select_n, 1'b1);
      check("companion selected", pmic_seen, 1'b1);
      $display("command test done");
   endtask

   task automatic t_light();
      ahb(1'b1, CTRL_OFS, 32'h3);
      wait_for(link.light_source_enable, 1'b1, 20);
      repeat (8) @(negedge hclk);
      check("driver held off", link.light_driver_on, 1'b0);
      wait_for(link.light_driver_on, 1'b1, 40);
      check("select follows", link.light_select, 2'h2);
      ahb(1'b1, CTRL_OFS, 32'h1);
      repeat (3) @(negedge hclk);
      check("driver forced off", link.light_driver_on, 1'b0);
      check("select forced", link.light_select, 2'h0);
      $display("light test done");
   endtask

   task automatic t_down();
      ahb(1'b1, CTRL_OFS, 32'h0);
      repeat (2) @(negedge hclk);
      check("parked first", link.mirror_rest_n, 1'b0);
      check("reset still high", link.power_on_reset_n, 1'b1);
      wait_for(link.power_on_reset_n, 1'b0, 40);
      check("supply off", supply_enable, 1'b0);
      check("outputs released", {link.mirror_power_enable_oe, link.flash_select_n_oe,
         link.serial_bus_clock_oe, link.light_driver_on_oe, link.light_select_oe,
         link.serial_bus_mosi_oe}, 6'h00);
      $display("shutdown test done");
   endtask

   initial begin
      hresetn = 1'b0;
      {hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
      {cmd_valid, cmd_pmic, cmd_data, cmd_hold} = '0;
      light_on_req = 1'b1;
      light_select_req = 2'h2;
      {mismatches, num_checks} = '0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      t_power();
      t_cmd();
      t_light();
      t_down();
      wrap_up();
   end
endmodule
`default_nettype wire
